// >>> swp_cpu_model.sv
// partner model: cpu core issuing sleep instructions, wake sources, pads
`timescale 1ns/1ps
module swp_cpu_model (
  input wire logic [5:0] src_req, // one bit per source, high one cycle
  input wire logic [7:0] ext_lvl, // level applied from outside
  input wire logic [7:0] pad_out, // pad drive value
  input wire logic [7:0] pad_oe, // pad drive enable
  output logic sleep_save_req, // power-save instruction
  output logic sleep_down_req, // power-down instruction
  output logic [1:0] timer8_wake, // 8-bit timer matches
  output logic wide_timer_wake, // 16-bit timer match
  output logic cmp_wake, // comparator event
  output logic [7:0] pad_in // resolved pad level
);
  // source bits: 0 save, 1 down, 2/3 timer8, 4 wide timer, 5 comparator
  assign sleep_save_req = src_req[0];
  assign sleep_down_req = src_req[1];
  assign timer8_wake = src_req[3:2];
  assign wide_timer_wake = src_req[4];
  assign cmp_wake = src_req[5];
  // a driven pin shows its latch, an input pin the outside level
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule : swp_cpu_model

// >>> swp_pad_ctrl.sv
// pad direction, pull control, read-back and wake toggle detect
`timescale 1ns/1ps
module swp_pad_ctrl (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire swp_pkg::swp_pad_cfg_t cfg, // pad configuration
  input wire logic [swp_pkg::NPIN-1:0] pad_in, // pad levels
  output logic [swp_pkg::NPIN-1:0] pad_out, // pad drive value
  output logic [swp_pkg::NPIN-1:0] pad_oe, // pad drive enable
  output logic [swp_pkg::NPIN-1:0] pull_up_en, // pull-high enable
  output logic [swp_pkg::NPIN-1:0] pull_dn_en, // pull-low enable
  output logic [swp_pkg::NPIN-1:0] port_rd, // port data read value
  output logic [swp_pkg::NPIN-1:0] toggle // wake toggle per pin
);
  logic [swp_pkg::NPIN-1:0] sync1;
  logic [swp_pkg::NPIN-1:0] sync2;
  logic [swp_pkg::NPIN-1:0] prev;
  logic [2:0] arm;

  // two-stage synchroniser, then one stage for edge detect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      prev <= '0;
      arm <= '0;
    end else begin
      sync1 <= pad_in;
      sync2 <= sync1;
      prev <= sync2;
      arm <= {arm[1:0], 1'b1};
    end
  end

  // drive and pulls; output mode ignores pulls, so low drive has no pull-up
  assign pad_oe = cfg.dir;
  assign pad_out = cfg.data;
  assign pull_up_en = ~cfg.dir & cfg.pull_h;
  assign pull_dn_en = ~cfg.dir & cfg.pull_l & ~cfg.pull_h;
  // outputs read the data latch, inputs read the pad
  assign port_rd = (cfg.dir & cfg.data) | (~cfg.dir & sync2);
  // only digital inputs with enable set can wake; arm hides the false
  // edge that prev, cleared by reset, would show against a high pad
  assign toggle = (sync2 ^ prev) & cfg.din_en & ~cfg.dir
                  & {swp_pkg::NPIN{arm[2]}};

  property p_no_pull_low_out;
    @(posedge hclk) disable iff (!hresetn)
      (pad_oe & ~pad_out & pull_up_en) == '0;
  endproperty
  a_no_pull_low_out: assert property (p_no_pull_low_out)
    else $error("pull-up on while pin drives low");
  property p_out_no_pull;
    @(posedge hclk) disable iff (!hresetn)
      (pad_oe & (pull_up_en | pull_dn_en)) == '0;
  endproperty
  a_out_no_pull: assert property (p_out_no_pull)
    else $error("pull enabled on an output pin");
  property p_rd_out;
    @(posedge hclk) disable iff (!hresetn)
      ((port_rd ^ pad_out) & pad_oe) == '0;
  endproperty
  a_rd_out: assert property (p_rd_out)
    else $error("output pin read does not return data latch");
endmodule : swp_pad_ctrl

// >>> swp_pkg.sv
// package: constants, types and register map of the sleep/wake/pin block
package swp_pkg;
  localparam int NPIN = 8;
  // register byte offsets on the AHB-Lite slave
  localparam logic [7:0] A_AUX_CTRL = 8'h00;
  localparam logic [7:0] A_PORT_DIR = 8'h04;
  localparam logic [7:0] A_PORT_DATA = 8'h08;
  localparam logic [7:0] A_PULL_HIGH = 8'h0C;
  localparam logic [7:0] A_PULL_LOW = 8'h10;
  localparam logic [7:0] A_DIG_IN_EN = 8'h14;
  localparam logic [7:0] A_CMP_CTRL = 8'h18;
  localparam logic [7:0] A_CMP_SELECT = 8'h1C;
  localparam logic [7:0] A_TMR8_NANO_SEL = 8'h20;
  localparam logic [7:0] A_STATUS = 8'h24;
  // field positions
  localparam int AUX_NANO_BIT = 0;
  localparam int AUX_HRC_BIT = 4;
  localparam int AUX_FAST_BIT = 5;
  localparam int CMP_EN_BIT = 7;
  localparam int CMP_WAKE_BIT = 6;
  // reset values
  localparam logic [7:0] AUX_RST = 8'h10;
  localparam logic [7:0] REG_RST = 8'h00;
  // timing: wake delays in low-speed RC periods
  localparam int NORMAL_WAKE_TICKS = 3000;
  localparam int FAST_WAKE_TICKS = 45;
  localparam int CLK_HZ = 25000000;
  localparam int LOW_RC_HZ = 62500;
  localparam int LOW_RC_DIV = CLK_HZ / LOW_RC_HZ;
  localparam int BOOT_SYNC_CYCLES = 3;
  // power states
  typedef enum logic [3:0] {
    SWP_RUN  = 4'b0001,
    SWP_SAVE = 4'b0010,
    SWP_DOWN = 4'b0100,
    SWP_WAKE = 4'b1000
  } swp_state_t;
  // pad configuration carried as one bundle
  typedef struct packed {
    logic [NPIN-1:0] dir;
    logic [NPIN-1:0] data;
    logic [NPIN-1:0] pull_h;
    logic [NPIN-1:0] pull_l;
    logic [NPIN-1:0] din_en;
  } swp_pad_cfg_t;
endpackage : swp_pkg

// >>> swp_sleep_ctrl.sv
// sleep/wake sequencer with pad control and AHB-Lite registers
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module swp_sleep_ctrl #(
  parameter int NORMAL_TICKS = swp_pkg::NORMAL_WAKE_TICKS,
  parameter int LOW_RC_DIV = swp_pkg::LOW_RC_DIV
) (
  input wire logic hclk, // 25 MHz clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write strobe
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // response, always okay
  output logic [31:0] hrdata, // read data
  input wire logic sleep_save_req, // power-save instruction pulse
  input wire logic sleep_down_req, // power-down instruction pulse
  input wire logic [1:0] timer8_wake, // 8-bit timer match pulses
  input wire logic wide_timer_wake, // 16-bit timer match pulse
  input wire logic cmp_wake, // comparator wake event pulse
  input wire logic power_on_cause, // reset came from power-on
  input wire logic [swp_pkg::NPIN-1:0] pad_in, // pad levels
  output logic [swp_pkg::NPIN-1:0] pad_out, // pad drive value
  output logic [swp_pkg::NPIN-1:0] pad_oe, // pad drive enable
  output logic [swp_pkg::NPIN-1:0] pull_up_en, // pull-high enable
  output logic [swp_pkg::NPIN-1:0] pull_dn_en, // pull-low enable
  output logic sys_clk_en, // system clock gate to CPU
  output logic prog_mem_en, // program memory power
  output logic high_rc_osc_en, // high-speed RC enable
  output logic low_rc_osc_en, // low-speed RC enable
  output logic nano_low_rc_osc_en, // nano RC enable
  output logic cmp_enable, // comparator enable
  output logic resume, // pulse: continue after sleep
  output logic restart_zero, // pulse: fetch from address zero
  output logic sram_clear // pulse: clear SRAM after power-on
);
  swp_pkg::swp_state_t state;
  swp_pkg::swp_state_t next_state;
  swp_pkg::swp_pad_cfg_t cfg;
  logic [7:0] aux_ctrl;
  logic [7:0] comparator_control;
  logic [7:0] comparator_select;
  logic [1:0] timer8_nano_sel;
  logic [3:0] wake_cause;
  logic from_down;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [swp_pkg::NPIN-1:0] port_rd;
  logic [swp_pkg::NPIN-1:0] toggle;
  logic pin_wake;
  logic t8_wake;
  logic t16_ok;
  logic cmp_ok;
  logic wake_down;
  logic wake_save;
  logic wake_evt;
  logic timer_done;
  logic timer_busy;
  logic addr_ok;
  logic por_s1;
  logic por_s2;
  logic [1:0] boot_cnt;
  // read mux for one register word
  function automatic logic [31:0] rd_word(input logic [7:0] a,
      input logic [7:0] pins);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      swp_pkg::A_AUX_CTRL: v = aux_ctrl;
      swp_pkg::A_PORT_DIR: v = cfg.dir;
      swp_pkg::A_PORT_DATA: v = pins;
      swp_pkg::A_PULL_HIGH: v = cfg.pull_h;
      swp_pkg::A_PULL_LOW: v = cfg.pull_l;
      swp_pkg::A_DIG_IN_EN: v = cfg.din_en;
      swp_pkg::A_CMP_CTRL: v = comparator_control;
      swp_pkg::A_CMP_SELECT: v = comparator_select;
      swp_pkg::A_TMR8_NANO_SEL: v = {6'h00, timer8_nano_sel};
      swp_pkg::A_STATUS: v = {wake_cause, state};
      default: v = 8'h00;
    endcase
    return {24'h000000, v};
  endfunction : rd_word
  // pad logic
  swp_pad_ctrl u_pad (
    .hclk(hclk),
    .hresetn(hresetn),
    .cfg(cfg),
    .pad_in(pad_in),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .pull_up_en(pull_up_en),
    .pull_dn_en(pull_dn_en),
    .port_rd(port_rd),
    .toggle(toggle)
  );
  // wake-up delay on the low-speed RC
  swp_wake_timer #(
    .DIV(LOW_RC_DIV),
    .NORMAL_TICKS(NORMAL_TICKS)
  ) u_wake (
    .hclk(hclk),
    .hresetn(hresetn),
    .osc_on(low_rc_osc_en),
    .start(wake_evt),
    .fast(aux_ctrl[swp_pkg::AUX_FAST_BIT]),
    .busy(timer_busy),
    .done(timer_done)
  );
  // bus: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && hready && htrans[1];
  // address phase capture and registered read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr <= haddr[7:0];
      end
      if (addr_ok && !hwrite) begin
        hrdata <= rd_word(haddr[7:0], port_rd);
      end
    end
  end
  // register writes; core is halted while not running, nothing changes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aux_ctrl <= swp_pkg::AUX_RST;
      cfg <= '0;
      comparator_control <= swp_pkg::REG_RST;
      comparator_select <= swp_pkg::REG_RST;
      timer8_nano_sel <= 2'h0;
    end else if (wr_pend && state == swp_pkg::SWP_RUN) begin
      unique case (wr_addr)
        swp_pkg::A_AUX_CTRL: aux_ctrl <= hwdata[7:0];
        swp_pkg::A_PORT_DIR: cfg.dir <= hwdata[7:0];
        swp_pkg::A_PORT_DATA: cfg.data <= hwdata[7:0];
        swp_pkg::A_PULL_HIGH: cfg.pull_h <= hwdata[7:0];
        swp_pkg::A_PULL_LOW: cfg.pull_l <= hwdata[7:0];
        swp_pkg::A_DIG_IN_EN: cfg.din_en <= hwdata[7:0];
        swp_pkg::A_CMP_CTRL: comparator_control <= hwdata[7:0];
        swp_pkg::A_CMP_SELECT: comparator_select <= hwdata[7:0];
        swp_pkg::A_TMR8_NANO_SEL: timer8_nano_sel <= hwdata[1:0];
        default: ;
      endcase
    end
  end
  // wake qualification per source
  assign pin_wake = |toggle;
  assign t8_wake = aux_ctrl[swp_pkg::AUX_NANO_BIT]
                   && |(timer8_wake & timer8_nano_sel);
  assign t16_ok = wide_timer_wake;
  assign cmp_ok = cmp_wake && comparator_control[swp_pkg::CMP_EN_BIT]
                  && comparator_select[swp_pkg::CMP_WAKE_BIT];
  assign wake_down = pin_wake || t8_wake;
  assign wake_save = wake_down || t16_ok || cmp_ok;
  assign wake_evt = (state == swp_pkg::SWP_DOWN && wake_down)
                    || (state == swp_pkg::SWP_SAVE && wake_save);
  // next power state
  always_comb begin
    next_state = state;
    unique case (state)
      swp_pkg::SWP_RUN: begin
        if (sleep_down_req) begin
          next_state = swp_pkg::SWP_DOWN;
        end else if (sleep_save_req) begin
          next_state = swp_pkg::SWP_SAVE;
        end
      end
      swp_pkg::SWP_SAVE, swp_pkg::SWP_DOWN: begin
        if (wake_evt) begin
          next_state = swp_pkg::SWP_WAKE;
        end
      end
      swp_pkg::SWP_WAKE: begin
        if (timer_done) begin
          next_state = swp_pkg::SWP_RUN;
        end
      end
      default: next_state = swp_pkg::SWP_RUN;
    endcase
  end
  // state register, wake origin and cause record
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= swp_pkg::SWP_RUN;
      from_down <= 1'b0;
      wake_cause <= 4'h0;
    end else begin
      state <= next_state;
      if (state == swp_pkg::SWP_RUN && sleep_down_req) begin
        from_down <= 1'b1;
      end else if (state == swp_pkg::SWP_RUN && sleep_save_req) begin
        from_down <= 1'b0;
      end
      if (wake_evt) begin
        wake_cause <= {cmp_ok, t16_ok, t8_wake, pin_wake};
      end
    end
  end
  // resume is a plain continuation: clock back on, no vector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resume <= 1'b0;
    end else begin
      resume <= state == swp_pkg::SWP_WAKE && timer_done;
    end
  end
  // clock and memory gating from the power state; nano RC and comparator enables from their register bits alone
  assign sys_clk_en = state == swp_pkg::SWP_RUN;
  assign prog_mem_en = state == swp_pkg::SWP_RUN;
  assign high_rc_osc_en = aux_ctrl[swp_pkg::AUX_HRC_BIT]
    && state != swp_pkg::SWP_DOWN
    && !(state == swp_pkg::SWP_WAKE && from_down);
  assign low_rc_osc_en = state != swp_pkg::SWP_DOWN;
  assign nano_low_rc_osc_en = aux_ctrl[swp_pkg::AUX_NANO_BIT];
  assign cmp_enable = comparator_control[swp_pkg::CMP_EN_BIT];
  // power-on cause passes two flops before use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_s1 <= 1'b0;
      por_s2 <= 1'b0;
    end else begin
      por_s1 <= power_on_cause;
      por_s2 <= por_s1;
    end
  end
  // after release: restart at zero; clear SRAM only after power-on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_cnt <= 2'h0;
      restart_zero <= 1'b0;
      sram_clear <= 1'b0;
    end else begin
      restart_zero <= 1'b0;
      sram_clear <= 1'b0;
      if (boot_cnt != 2'(swp_pkg::BOOT_SYNC_CYCLES)) begin
        boot_cnt <= boot_cnt + 2'h1;
        if (boot_cnt == 2'(swp_pkg::BOOT_SYNC_CYCLES - 1)) begin
          restart_zero <= 1'b1;
          sram_clear <= por_s2;
        end
      end
    end
  end
  property p_down_osc;
    @(posedge hclk) disable iff (!hresetn)
      state == swp_pkg::SWP_DOWN |-> !high_rc_osc_en && !low_rc_osc_en
        && !sys_clk_en;
  endproperty
  a_down_osc: assert property (p_down_osc)
    else $error("oscillator running in power-down");
  property p_no_fetch;
    @(posedge hclk) disable iff (!hresetn)
      !sys_clk_en |-> !prog_mem_en;
  endproperty
  a_no_fetch: assert property (p_no_fetch)
    else $error("program memory on while asleep");
  property p_hold;
    @(posedge hclk) disable iff (!hresetn)
      !sys_clk_en && !$past(sys_clk_en) |-> $stable(cfg)
        && $stable(aux_ctrl);
  endproperty
  a_hold: assert property (p_hold)
    else $error("register changed during sleep");
  property p_down_wake;
    @(posedge hclk) disable iff (!hresetn)
      state == swp_pkg::SWP_DOWN && wake_down
        |=> state == swp_pkg::SWP_WAKE && timer_busy;
  endproperty
  a_down_wake: assert property (p_down_wake)
    else $error("power-down did not wake on pin or nano timer");
  property p_down_ignore;
    @(posedge hclk) disable iff (!hresetn)
      state == swp_pkg::SWP_DOWN && !pin_wake && !t8_wake
        |=> state == swp_pkg::SWP_DOWN;
  endproperty
  a_down_ignore: assert property (p_down_ignore)
    else $error("power-down left without valid source");
  property p_cmp_gate;
    @(posedge hclk) disable iff (!hresetn)
      state == swp_pkg::SWP_SAVE && !wake_down && !t16_ok
        && !(comparator_control[swp_pkg::CMP_EN_BIT]
        && comparator_select[swp_pkg::CMP_WAKE_BIT])
        |=> state == swp_pkg::SWP_SAVE;
  endproperty
  a_cmp_gate: assert property (p_cmp_gate)
    else $error("comparator woke without both enables");
  property p_resume;
    @(posedge hclk) disable iff (!hresetn)
      $rose(sys_clk_en) |-> resume && !restart_zero;
  endproperty
  a_resume: assert property (p_resume)
    else $error("wake did not resume as continuation");
  property p_save_osc;
    @(posedge hclk) disable iff (!hresetn)
      state == swp_pkg::SWP_SAVE |-> low_rc_osc_en && !sys_clk_en
        && high_rc_osc_en == aux_ctrl[swp_pkg::AUX_HRC_BIT];
  endproperty
  a_save_osc: assert property (p_save_osc)
    else $error("power-save stopped an oscillator");
  c_down_wake: cover property (@(posedge hclk) disable iff (!hresetn)
    state == swp_pkg::SWP_DOWN ##1 state == swp_pkg::SWP_WAKE);
  c_save_cmp: cover property (@(posedge hclk) disable iff (!hresetn)
    state == swp_pkg::SWP_SAVE && cmp_ok);
  c_fast_resume: cover property (@(posedge hclk) disable iff (!hresetn)
    resume && aux_ctrl[swp_pkg::AUX_FAST_BIT]);
endmodule : swp_sleep_ctrl

// >>> swp_wake_timer.sv
// low-speed RC tick divider and wake-up delay counter
`timescale 1ns/1ps
module swp_wake_timer #(
  parameter int DIV = swp_pkg::LOW_RC_DIV,
  parameter int NORMAL_TICKS = swp_pkg::NORMAL_WAKE_TICKS
) (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic osc_on, // low-speed RC running
  input wire logic start, // wake event, restarts the count
  input wire logic fast, // fast wake selected
  output logic busy, // delay in progress
  output logic done // pulse when delay expires
);
  logic [15:0] div_cnt;
  logic [11:0] tick_cnt;
  logic fast_q;
  logic tick;
  logic [11:0] target;
  logic [31:0] cyc;

  // divider models the RC oscillator; it restarts with the wake event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= '0;
    end else if (start || !osc_on || tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end
  assign tick = osc_on && !start && (div_cnt == 16'(DIV - 1));

  // delay counter counts ticks until the selected total
  assign target = fast_q ? 12'(swp_pkg::FAST_WAKE_TICKS)
                         : 12'(NORMAL_TICKS);
  assign done = busy && tick && (tick_cnt == target - 12'h001);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      tick_cnt <= '0;
      fast_q <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
      tick_cnt <= '0;
      fast_q <= fast;
    end else if (done) begin
      busy <= 1'b0;
    end else if (busy && tick) begin
      tick_cnt <= tick_cnt + 12'h001;
    end
  end

  // helper: cycles since the last start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc <= '0;
    end else if (start) begin
      cyc <= 32'h00000001;
    end else begin
      cyc <= cyc + 32'h00000001;
    end
  end
  property p_delay;
    @(posedge hclk) disable iff (!hresetn)
      done |-> cyc == 32'(int'(target) * DIV);
  endproperty
  a_delay: assert property (p_delay)
    else $error("wake delay length wrong");
endmodule : swp_wake_timer

// >>> test_sleep_wakeup_and_pin_control.sv
// testbench: sleep/wake sequencing, pad control and register access
`timescale 1ns/1ps
module test_sleep_wakeup_and_pin_control;
  localparam int NT = 50;
  localparam int DV = 4;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, por;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic ss, sd, wt, cw, sys_clk_en, prog_mem_en, hrc, lrc, nrc, cmp_enable;
  logic resume, restart_zero, sram_clear;
  logic [1:0] t8;
  logic [7:0] pad_in, pad_out, pad_oe, pull_up_en, pull_dn_en;
  logic [7:0] ext_lvl;
  logic [5:0] src_req;
  int num_errors = 0;
  int checks_done = 0;
  int rz_cnt = 0;
  int sc_cnt = 0;
  int cyc = 0;
  int n;

  swp_sleep_ctrl #(.NORMAL_TICKS(NT), .LOW_RC_DIV(DV)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .sleep_save_req(ss), .sleep_down_req(sd), .timer8_wake(t8),
    .wide_timer_wake(wt), .cmp_wake(cw), .power_on_cause(por),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en),
    .sys_clk_en(sys_clk_en), .prog_mem_en(prog_mem_en),
    .high_rc_osc_en(hrc), .low_rc_osc_en(lrc), .nano_low_rc_osc_en(nrc),
    .cmp_enable(cmp_enable), .resume(resume), .restart_zero(restart_zero),
    .sram_clear(sram_clear));

  swp_cpu_model i_cpu (
    .src_req(src_req), .ext_lvl(ext_lvl), .pad_out(pad_out),
    .pad_oe(pad_oe), .sleep_save_req(ss), .sleep_down_req(sd),
    .timer8_wake(t8), .wide_timer_wake(wt), .cmp_wake(cw), .pad_in(pad_in));

  // clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // pulse counters and run limit
  always @(posedge hclk) begin
    if (restart_zero === 1'b1) rz_cnt++;
    if (sram_clear === 1'b1) sc_cnt++;
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end

  // compare and count
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one single word transfer, waiting on hready in both phases
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  // one-cycle source pulse: 0 save, 1 down, 2/3 timer8, 4 wide, 5 comparator
  task automatic pulse(input int src);
    @(posedge hclk);
    src_req <= 6'h01 << src;
    @(posedge hclk);
    src_req <= 6'h00;
  endtask : pulse

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(nm, x, e);
  endtask : rdc

  // reset for 12 cycles with the given cause
  task automatic do_reset(input logic p);
    @(posedge hclk);
    hresetn <= 1'b0;
    por <= p;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask : do_reset

  // edges from the wake event until resume shows
  task automatic wake_time(output int m);
    m = 0;
    while (resume !== 1'b1 && m < 5000) begin
      @(posedge hclk);
      #1;
      m++;
    end
  endtask : wake_time

  task automatic t_reset;
    do_reset(1'b1);
    check("restart", rz_cnt, 1);
    check("sram_clear", sc_cnt, 1);
    rdc("aux", swp_pkg::A_AUX_CTRL, 32'h10);
    rdc("status", swp_pkg::A_STATUS, 32'h01);
    check("hresp", hresp, 1'b0);
    wr(swp_pkg::A_PULL_HIGH, 32'h33);
    do_reset(1'b0);
    check("restart", rz_cnt, 2);
    check("sram_kept", sc_cnt, 1);
    rdc("pull_high", swp_pkg::A_PULL_HIGH, 32'h00);
  endtask : t_reset

  task automatic t_pads;
    wr(swp_pkg::A_PORT_DIR, 32'hF0);
    wr(swp_pkg::A_PORT_DATA, 32'hA5);
    wr(swp_pkg::A_PULL_HIGH, 32'h33);
    wr(swp_pkg::A_PULL_LOW, 32'h5A);
    #1;
    check("pad_oe", pad_oe, 8'hF0);
    check("pad_out", pad_out, 8'hA5);
    check("pull_up", pull_up_en, 8'h03);
    check("pull_dn", pull_dn_en, 8'h08);
    repeat (4) @(posedge hclk);
    rdc("port_rd", swp_pkg::A_PORT_DATA, 32'hA6);
  endtask : t_pads

  task automatic t_down;
    wr(swp_pkg::A_AUX_CTRL, 32'h00);
    wr(swp_pkg::A_CMP_CTRL, 32'h00);
    wr(swp_pkg::A_PORT_DIR, 32'h00);
    wr(swp_pkg::A_DIG_IN_EN, 32'h01);
    pulse(1);
    #1;
    check("clk_en", sys_clk_en, 1'b0);
    check("osc", {hrc, lrc}, 2'h0);
    check("prog_mem", prog_mem_en, 1'b0);
    @(posedge hclk);
    ext_lvl <= 8'h04;
    repeat (10) @(posedge hclk);
    #1;
    check("still_down", sys_clk_en, 1'b0);
    @(posedge hclk);
    ext_lvl <= 8'h05;
    wake_time(n);
    check("wake_normal", n >= NT * DV && n <= NT * DV + 5, 1'b1);
    check("no_restart", rz_cnt, 2);
    rdc("din_kept", swp_pkg::A_DIG_IN_EN, 32'h01);
  endtask : t_down

  task automatic t_save;
    wr(swp_pkg::A_AUX_CTRL, 32'h21);
    wr(swp_pkg::A_TMR8_NANO_SEL, 32'h01);
    pulse(0);
    #1;
    check("save_osc", {sys_clk_en, lrc, nrc}, 3'h3);
    pulse(3);
    pulse(5);
    #1;
    check("ignored", sys_clk_en, 1'b0);
    pulse(2);
    wake_time(n);
    check("fast_t8", n, 45 * DV);
    pulse(0);
    pulse(4);
    wake_time(n);
    check("fast_wide", n, 45 * DV);
    wr(swp_pkg::A_CMP_CTRL, 32'h80);
    wr(swp_pkg::A_CMP_SELECT, 32'h40);
    #1;
    check("cmp_en", cmp_enable, 1'b1);
    pulse(0);
    pulse(5);
    wake_time(n);
    check("fast_cmp", n, 45 * DV);
    pulse(1);
    pulse(5);
    pulse(4);
    #1;
    check("down_ignore", sys_clk_en, 1'b0);
    pulse(2);
    wake_time(n);
    check("down_t8", n, 45 * DV);
    check("no_restart", rz_cnt, 2);
    rdc("cause", swp_pkg::A_STATUS, 32'h21);
  endtask : t_save

  // verdict and end of run
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  // main sequence
  initial begin
    hresetn = 1'b0;
    por = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    ext_lvl = 8'h06;
    src_req = 6'h00;
    t_reset();
    t_pads();
    t_down();
    t_save();
    summarize();
  end
endmodule : test_sleep_wakeup_and_pin_control
